// ===== verilog/ftl_pkg.sv
// Package for the fan, tachometer and status lamp register group.
// Assumes a single 250 MHz clock and a byte-addressed register port.
package ftl_pkg;
  // Register offsets
  localparam logic [7:0] FTL_OFF_DUTY_ONE   = 8'h56;
  localparam logic [7:0] FTL_OFF_DUTY_TWO   = 8'h57;
  localparam logic [7:0] FTL_OFF_FAN_SETUP  = 8'h58;
  localparam logic [7:0] FTL_OFF_CNT_ONE    = 8'h59;
  localparam logic [7:0] FTL_OFF_CNT_TWO    = 8'h5A;
  localparam logic [7:0] FTL_OFF_START_ONE  = 8'h5B;
  localparam logic [7:0] FTL_OFF_START_TWO  = 8'h5C;
  localparam logic [7:0] FTL_OFF_LAMP_ONE   = 8'h5D;
  localparam logic [7:0] FTL_OFF_LAMP_TWO   = 8'h5E;
  localparam logic [7:0] FTL_OFF_SCAN       = 8'h5F;
  localparam logic [7:0] FTL_OFF_RSVD_LO    = 8'h60;
  localparam logic [7:0] FTL_OFF_RSVD_HI    = 8'h7F;

  // Reset values
  localparam logic [7:0] FTL_RST_FAN_SETUP  = 8'h50;
  localparam logic [7:0] FTL_RST_BYTE       = 8'h00;

  // Fan setup field positions
  localparam int FTL_SRC_LSB  = 0;  // Source select, one bit per fan
  localparam int FTL_DBL_LSB  = 2;  // Doubling, one bit per fan
  localparam int FTL_DIV_LSB  = 4;  // Count divisor, two bits per fan
  // Duty register field positions
  localparam int FTL_FORCE_BIT = 0;
  localparam int FTL_DUTY_LSB  = 1;
  localparam int FTL_DUTY_MSB  = 6;
  localparam int FTL_CSEL_BIT  = 7;

  // Lamp modes
  typedef enum logic [1:0] {
    FTL_LAMP_OFF  = 2'h0,
    FTL_LAMP_FAST = 2'h1,
    FTL_LAMP_SLOW = 2'h2,
    FTL_LAMP_ON   = 2'h3
  } ftl_lamp_mode_t;

  // Timing
  localparam int FTL_CLK_PERIOD_NS = 4;
  localparam int FTL_LAMP_PHASE_MS = 500;
  localparam int FTL_LAMP_PHASE_CYC =
    FTL_LAMP_PHASE_MS * (1000000 / FTL_CLK_PERIOD_NS);

  // Base fan step dividers chosen by {clock select, source select}
  localparam logic [15:0] FTL_FAN_DIV_0 = 16'h0100;
  localparam logic [15:0] FTL_FAN_DIV_1 = 16'h0200;
  localparam logic [15:0] FTL_FAN_DIV_2 = 16'h0800;
  localparam logic [15:0] FTL_FAN_DIV_3 = 16'h2000;
  // Tachometer counting clock prescale before the count divisor
  localparam logic [15:0] FTL_TACH_BASE_DIV = 16'h0400;
endpackage : ftl_pkg

// ===== verilog/ftl_regs.sv
// Fan speed, tachometer, status lamp and scan-code register group.
// Assumes tachometer inputs are synchronous to sys_clk and a simple
// strobe register port with read data one cycle after the read strobe.
//
// Overview of operation
// - Fan one speed from source, select, doubling
// - Fan two speed from source, select, doubling
// - Setup bit 2 doubles fan one speed
// - Setup bit 3 doubles fan two speed
// - Bits 5:4 divide fan one count clock
// - Bits 7:6 divide fan two count clock
// - Fan setup register resets to 0x50
// - Count clock ticks per pulse, eight bits
// - Latch final count of previous pulse
// - Count starts from the preload value
// - Preload write restarts that fan's counting
// - Lamp codes off, 1 Hz half duty, on
// - Lamp code 10 blinks quarter duty slowly
// - Scan-code byte stored and read back
// - Reserved offsets and lamp bits read zero
// - Duty bit 0 forces fan output high
// - Six-bit duty sets high steps of 64
//
// Register map, byte offsets on the register port
// 0x56 fan one duty: bit 0 force high, bits 6:1 duty, bit 7 clock select
// 0x57 fan two duty, same layout as fan one
// 0x58 fan setup: bits 1:0 source select, bits 3:2 doubling
//      bits 5:4 fan one count divisor, bits 7:6 fan two count divisor
// 0x59 fan one speed count, read only
// 0x5A fan two speed count, read only
// 0x5B fan one count start value
// 0x5C fan two count start value
// 0x5D lamp one mode in bits 1:0, upper bits read zero
// 0x5E lamp two mode in bits 1:0, upper bits read zero
// 0x5F scan-code byte, plain storage
// 0x60 to 0x7F reserved; these and unmapped offsets read zero
// Writes to read-only, reserved or unmapped offsets are dropped.
//
// Structure
// One shared timebase steps a two-bit blink phase for both lamps.
// Each fan has a step prescaler feeding a 64-step duty counter.
// Each fan has a count clock: a fixed prescale, then its divisor.
// A live count runs per pulse; a rising tachometer edge latches it.
// Speed counts stop at 0xFF instead of wrapping.
// Read data is registered, so the decode adds no output path.
// All state sits behind clk_en, so a low enable freezes the block.
//
// Latency
// Read data stands for the one cycle after the read strobe, else zero.
// A duty write reaches its fan pin two edges after it is taken.
// A lamp mode write reaches its lamp pin one edge after it is taken.
// A speed count updates at the edge that sees its tachometer rise.
//
// Limitations
// Tachometer inputs must be clean and synchronous; nothing filters them.
// A count read within two pulses of a start write may be stale.
// The blink phase runs free, so the first blink after a mode write
// may be shorter than a full phase.
// A new fan step rate takes hold at once; a smaller one ends the current step.
// Lamp and fan pins are low during reset.
//
// The plain strobed port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module ftl_regs
  import ftl_pkg::*;
#(
  parameter int LAMP_PHASE_CYC = FTL_LAMP_PHASE_CYC
) (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       clk_en,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       fan_tach_one,
  input  wire logic       fan_tach_two,
  output logic            fan_out_one,
  output logic            fan_out_two,
  output logic            status_lamp_one,
  output logic            status_lamp_two
);

  // Tachometer count clock divisor from a two-bit code
  // The default arm stands for code 3, divide by eight
  function automatic logic [3:0] tach_div(input logic [1:0] code);
    case (code)
      2'h0:    tach_div = 4'h1;
      2'h1:    tach_div = 4'h2;
      2'h2:    tach_div = 4'h4;
      default: tach_div = 4'h8;
    endcase
  endfunction : tach_div

  // Fan step divider; doubling the speed halves the divider
  // Halving keeps the 64-step duty shape at twice the rate
  function automatic logic [15:0] fan_step(input logic src,
                                           input logic csel,
                                           input logic dbl);
    logic [15:0] base;
    base = FTL_FAN_DIV_0;
    case ({csel, src})
      2'h0:    base = FTL_FAN_DIV_0;
      2'h1:    base = FTL_FAN_DIV_1;
      2'h2:    base = FTL_FAN_DIV_2;
      default: base = FTL_FAN_DIV_3;
    endcase
    fan_step = dbl ? {1'b0, base[15:1]} : base;
  endfunction : fan_step

  // Lamp pin level for a mode and the shared blink phase
  // One phase source keeps both lamps blinking in step
  function automatic logic lamp_level(input logic [1:0] mode,
                                      input logic [1:0] phase);
    case (ftl_lamp_mode_t'(mode))
      FTL_LAMP_OFF:  lamp_level = 1'b0;
      FTL_LAMP_FAST: lamp_level = ~phase[0];
      FTL_LAMP_SLOW: lamp_level = (phase == 2'h0);
      FTL_LAMP_ON:   lamp_level = 1'b1;
      default:       lamp_level = 1'b0;
    endcase
  endfunction : lamp_level

  // Register state and per-fan wiring
  logic [7:0]  fan_setup_q;
  logic [7:0]  duty_q     [2];
  logic [7:0]  start_q    [2];
  logic [7:0]  count_q    [2];
  logic [1:0]  lamp_q     [2];
  logic [7:0]  scan_q;
  logic        fan_pin    [2];
  logic [7:0]  rdata_d;
  logic [31:0] lamp_cnt_q;
  logic [1:0]  lamp_phase_q;
  logic [1:0]  tach_pin;
  logic        wr_start   [2];

  // Pins as vectors; start writes also restart counting
  assign tach_pin[0] = fan_tach_one;
  assign tach_pin[1] = fan_tach_two;
  assign wr_start[0] = reg_wr && (reg_addr == FTL_OFF_START_ONE);
  assign wr_start[1] = reg_wr && (reg_addr == FTL_OFF_START_TWO);

  // Fan setup register
  // Only the register port writes it; no hardware side effects
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fan_setup_q <= FTL_RST_FAN_SETUP;
    end else if (clk_en && reg_wr && reg_addr == FTL_OFF_FAN_SETUP) begin
      fan_setup_q <= reg_wdata;
    end
  end

  // Scan-code holding byte
  // Plain storage, read back unchanged
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      scan_q <= FTL_RST_BYTE;
    end else if (clk_en && reg_wr && reg_addr == FTL_OFF_SCAN) begin
      scan_q <= reg_wdata;
    end
  end

  // Lamp mode fields; upper bits are not stored
  // Dropping bits 7:2 is what makes them read zero
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lamp_q[0] <= FTL_RST_BYTE[1:0];
      lamp_q[1] <= FTL_RST_BYTE[1:0];
    end else if (clk_en && reg_wr) begin
      if (reg_addr == FTL_OFF_LAMP_ONE) begin
        lamp_q[0] <= reg_wdata[1:0];
      end
      if (reg_addr == FTL_OFF_LAMP_TWO) begin
        lamp_q[1] <= reg_wdata[1:0];
      end
    end
  end

  // Shared half-second timebase and four-step blink phase
  // Free running; a mode write does not restart the phase
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lamp_cnt_q   <= 32'h0;
      lamp_phase_q <= 2'h0;
    end else if (clk_en) begin
      if (lamp_cnt_q == 32'(LAMP_PHASE_CYC - 1)) begin
        lamp_cnt_q   <= 32'h0;
        lamp_phase_q <= lamp_phase_q + 2'h1;
      end else begin
        lamp_cnt_q <= lamp_cnt_q + 32'h1;
      end
    end
  end

  // Lamp pins
  // Registered so the pins carry no decode glitches
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_lamp_one <= 1'b0;
      status_lamp_two <= 1'b0;
    end else if (clk_en) begin
      status_lamp_one <= lamp_level(lamp_q[0], lamp_phase_q);
      status_lamp_two <= lamp_level(lamp_q[1], lamp_phase_q);
    end
  end

  // Per-fan duty output and tachometer measurement
  for (genvar f = 0; f < 2; f++) begin : g_fan
    logic [15:0] step_cnt_q;
    logic [5:0]  pwm_cnt_q;
    logic [15:0] pre_cnt_q;
    logic [3:0]  div_cnt_q;
    logic [7:0]  live_q;
    logic        tach_dly_q;
    logic [15:0] step_lim;
    logic        count_tick;
    logic        pulse_edge;
    logic        pre_wrap;

    // Fan step rate from source, select and doubling bits
    // Rising tachometer edge and count clock tick strobes
    assign step_lim = fan_step(fan_setup_q[FTL_SRC_LSB + f],
                               duty_q[f][FTL_CSEL_BIT],
                               fan_setup_q[FTL_DBL_LSB + f]);
    assign pulse_edge = tach_pin[f] && !tach_dly_q;
    assign pre_wrap   = (pre_cnt_q == FTL_TACH_BASE_DIV - 16'h1);
    assign count_tick = pre_wrap &&
      (div_cnt_q == tach_div(fan_setup_q[FTL_DIV_LSB + 2*f +: 2])
                    - 4'h1);

    // Duty register
    // Address offset by fan index picks this fan's register
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        duty_q[f] <= FTL_RST_BYTE;
      end else if (clk_en && reg_wr &&
                   reg_addr == FTL_OFF_DUTY_ONE + 8'(f)) begin
        duty_q[f] <= reg_wdata;
      end
    end

    // Step prescaler and 64-step duty counter
    // Compare with >= so a smaller new divider wraps at once
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        step_cnt_q <= 16'h0;
        pwm_cnt_q  <= 6'h0;
      end else if (clk_en) begin
        if (step_cnt_q >= step_lim - 16'h1) begin
          step_cnt_q <= 16'h0;
          pwm_cnt_q  <= pwm_cnt_q + 6'h1;
        end else begin
          step_cnt_q <= step_cnt_q + 16'h1;
        end
      end
    end

    // Fan pin: forced high, else high while step below duty
    // Duty zero never matches, so the pin stays low
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        fan_pin[f] <= 1'b0;
      end else if (clk_en) begin
        fan_pin[f] <= duty_q[f][FTL_FORCE_BIT] ||
          (pwm_cnt_q < duty_q[f][FTL_DUTY_MSB:FTL_DUTY_LSB]);
      end
    end

    // Preload register
    // Reloaded into the live count at every pulse edge
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        start_q[f] <= FTL_RST_BYTE;
      end else if (clk_en && wr_start[f]) begin
        start_q[f] <= reg_wdata;
      end
    end

    // Counting clock: base prescale then the selected divisor
    // A start write clears both so the next tick is a full one
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        pre_cnt_q <= 16'h0;
        div_cnt_q <= 4'h0;
      end else if (clk_en) begin
        if (wr_start[f]) begin
          pre_cnt_q <= 16'h0;
          div_cnt_q <= 4'h0;
        end else if (pre_wrap) begin
          pre_cnt_q <= 16'h0;
          div_cnt_q <= count_tick ? 4'h0 : div_cnt_q + 4'h1;
        end else begin
          pre_cnt_q <= pre_cnt_q + 16'h1;
        end
      end
    end

    // Live count per pulse, reloaded on each pulse edge
    // A start write wins over an edge in the same cycle
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        live_q     <= FTL_RST_BYTE;
        tach_dly_q <= 1'b0;
      end else if (clk_en) begin
        tach_dly_q <= tach_pin[f];
        if (wr_start[f]) begin
          live_q <= reg_wdata;
        end else if (pulse_edge) begin
          live_q <= start_q[f];
        end else if (count_tick && live_q != 8'hFF) begin
          live_q <= live_q + 8'h1;
        end
      end
    end

    // Readable count holds the final count of the last pulse
    // Skipped when a start write lands on the edge cycle
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        count_q[f] <= FTL_RST_BYTE;
      end else if (clk_en && pulse_edge && !wr_start[f]) begin
        count_q[f] <= live_q;
      end
    end
  end : g_fan

  // Fan pins to ports
  // Extra stage keeps every output straight from a flop
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fan_out_one <= 1'b0;
      fan_out_two <= 1'b0;
    end else if (clk_en) begin
      fan_out_one <= fan_pin[0];
      fan_out_two <= fan_pin[1];
    end
  end

  // Read decode; reserved and unmapped offsets read zero
  // One case feeds the read register; no read side effects
  always_comb begin
    rdata_d = 8'h00;
    case (reg_addr)
      FTL_OFF_DUTY_ONE:  rdata_d = duty_q[0];
      FTL_OFF_DUTY_TWO:  rdata_d = duty_q[1];
      FTL_OFF_FAN_SETUP: rdata_d = fan_setup_q;
      FTL_OFF_CNT_ONE:   rdata_d = count_q[0];
      FTL_OFF_CNT_TWO:   rdata_d = count_q[1];
      FTL_OFF_START_ONE: rdata_d = start_q[0];
      FTL_OFF_START_TWO: rdata_d = start_q[1];
      FTL_OFF_LAMP_ONE:  rdata_d = {6'h00, lamp_q[0]};
      FTL_OFF_LAMP_TWO:  rdata_d = {6'h00, lamp_q[1]};
      FTL_OFF_SCAN:      rdata_d = scan_q;
      default:           rdata_d = 8'h00;
    endcase
  end

  // Read data stands one cycle after the strobe, zero otherwise
  // Zero outside the answer cycle, so a stale read cannot show
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (clk_en) begin
      reg_rdata <= reg_rd ? rdata_d : 8'h00;
    end
  end

endmodule : ftl_regs
`default_nettype wire

// ===== verif/ftl_regs_assertions.sv
// Checker for the fan, tachometer and lamp register group.
// Bound to ftl_regs; it sees the ports only.
`timescale 1ns/100ps
`default_nettype none
module ftl_regs_chk
  import ftl_pkg::*;
#(
  parameter int LAMP_PHASE_CYC = 8
) (
  input wire logic       sys_clk,
  input wire logic       rst_n,
  input wire logic       clk_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       fan_tach_one,
  input wire logic       fan_tach_two,
  input wire logic       fan_out_one,
  input wire logic       fan_out_two,
  input wire logic       status_lamp_one,
  input wire logic       status_lamp_two
);
  logic [7:0] sh_q [0:9];
  logic [7:0] exp_q;
  logic [3:0] ix;
  logic       wable;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Decode of the writable offsets
  assign ix    = 4'(reg_addr - 8'h56);
  assign wable = (reg_addr inside {[8'h56:8'h5F]}) && !(reg_addr inside {8'h59, 8'h5A});
  // Shadow of every writable register, lamp bits masked
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 10; i++)
        sh_q[i] <= (i == 2) ? FTL_RST_FAN_SETUP : FTL_RST_BYTE;
      exp_q <= 8'h00;
    end else if (clk_en) begin
      if (reg_wr && wable)
        sh_q[ix] <= reg_wdata & ((ix inside {4'h7, 4'h8}) ? 8'h03 : 8'hFF);
      exp_q <= sh_q[ix];
    end
  end
  a_rdata_idle_zero: assert property (clk_en && !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero outside answer");
  a_rsvd_read_zero: assert property (clk_en && reg_rd && reg_addr >= 8'h60 |=> reg_rdata == 8'h00)
    else $error("reserved read not zero");
  a_reg_readback: assert property (clk_en && reg_rd && wable |=> reg_rdata == exp_q)
    else $error("register read back wrong");
  a_lamp_one_off: assert property ((sh_q[7][1:0] == 2'h0)[*2] |-> !status_lamp_one)
    else $error("lamp one lit while off");
  a_lamp_one_on: assert property ((sh_q[7][1:0] == 2'h3)[*2] |-> status_lamp_one)
    else $error("lamp one dark while on");
  a_lamp_two_off: assert property ((sh_q[8][1:0] == 2'h0)[*2] |-> !status_lamp_two)
    else $error("lamp two lit while off");
  a_fan_one_force: assert property (sh_q[0][0] [*3] |-> fan_out_one)
    else $error("fan one not forced high");
  a_fan_two_force: assert property (sh_q[1][0] [*3] |-> fan_out_two)
    else $error("fan two not forced high");
  a_fan_one_idle: assert property ((sh_q[0][6:0] == 7'h00)[*3] |-> !fan_out_one)
    else $error("fan one high at zero duty");
  c_scan_read: cover property (reg_rd && reg_addr == 8'h5F);
  c_lamps_lit: cover property (status_lamp_one && status_lamp_two);
  c_fan_two_rise: cover property ($rose(fan_out_two));
endmodule : ftl_regs_chk
bind ftl_regs ftl_regs_chk #(.LAMP_PHASE_CYC(LAMP_PHASE_CYC)) ftl_regs_chk_i (
  .sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .fan_tach_one(fan_tach_one), .fan_tach_two(fan_tach_two), .fan_out_one(fan_out_one),
  .fan_out_two(fan_out_two), .status_lamp_one(status_lamp_one),
  .status_lamp_two(status_lamp_two));
`default_nettype wire

// ===== verif/ftl_fan_model.sv
// Fan model: one tachometer pulse per revolution.
// Assumes pulses are synchronous to sys_clk.
`timescale 1ns/100ps
`default_nettype none
module ftl_fan_model #(
  parameter int PERIOD = 300
) (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic fan_drive,
  output logic      tach
);
  int   cnt_q;
  logic spin_q;
  // Revolution counter, a one-cycle pulse per turn once first driven
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q  <= 0;
      tach   <= 1'b0;
      spin_q <= 1'b0;
    end else begin
      spin_q <= spin_q || fan_drive;
      if (spin_q) begin
        cnt_q <= (cnt_q == PERIOD - 1) ? 0 : cnt_q + 1;
        tach  <= (cnt_q == PERIOD - 1);
      end
    end
  end
endmodule : ftl_fan_model
`default_nettype wire

// ===== verif/ftl_regs_test.sv
// Self-checking bench for the fan, tachometer and lamp register group.
// Assumes the package and the fan model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module ftl_regs_test
  import ftl_pkg::*;
;
  logic       sys_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       clk_en = 1'b1;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic       pend = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic       tach_one, tach_two, fan_one, fan_two, lamp_one, lamp_two;
  logic [7:0] exp_q [$];
  int         fails = 0;
  int         check_count = 0;
  ftl_regs #(.LAMP_PHASE_CYC(8)) ftl_regs_i (.sys_clk(sys_clk), .rst_n(rst_n),
    .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fan_tach_one(tach_one),
    .fan_tach_two(tach_two), .fan_out_one(fan_one), .fan_out_two(fan_two),
    .status_lamp_one(lamp_one), .status_lamp_two(lamp_two));
  ftl_fan_model #(.PERIOD(5000)) fan_one_m (.sys_clk(sys_clk), .rst_n(rst_n),
    .fan_drive(fan_one), .tach(tach_one));
  ftl_fan_model #(.PERIOD(300)) fan_two_m (.sys_clk(sys_clk), .rst_n(rst_n),
    .fan_drive(fan_two), .tach(tach_two));
  // Clock
  always #2 sys_clk = ~sys_clk;
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    exp_q.push_back(e);
    @(posedge sys_clk);
    reg_rd <= 1'b0;
  endtask : rd
  task automatic tally_and_finish;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish
  // Read answers meet the oldest note one cycle after the strobe
  always @(posedge sys_clk) pend <= reg_rd;
  always @(negedge sys_clk) begin
    if (pend) chk("read data", 16'(reg_rdata), 16'(exp_q.pop_front()));
  end
  // Main sequence
  initial begin
    logic [7:0]  s;
    logic [15:0] n1, n2;
    s = 8'h01;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int a = 'h56; a <= 'h60; a++) rd(8'(a), (a == 'h58) ? FTL_RST_FAN_SETUP : 8'h00);
    rd(8'h7F, 8'h00);
    repeat (4) begin
      s = lfsr(s);
      wr(8'h5F, s);
      rd(8'h5F, s);
      wr(8'h5E, s);
      rd(8'h5E, s & 8'h03);
      wr(8'h59, s);
      rd(8'h59, 8'h00);
      wr(8'h60, s);
      rd(8'h60, 8'h00);
    end
    wr(8'h5D, 8'h01);
    wr(8'h5E, 8'h02);
    repeat (4) @(negedge sys_clk);
    n1 = 16'h0000;
    n2 = 16'h0000;
    repeat (32) begin
      @(negedge sys_clk);
      n1 += 16'(lamp_one);
      n2 += 16'(lamp_two);
    end
    chk("lamp one lit", n1, 16'h0010);
    chk("lamp two lit", n2, 16'h0008);
    wr(8'h5D, 8'h03);
    wr(8'h5E, 8'h00);
    wr(8'h56, 8'h01);
    wr(8'h57, 8'h01);
    repeat (4) @(negedge sys_clk);
    chk("lamp one on", 16'(lamp_one), 16'h0001);
    chk("fan one forced", 16'(fan_one), 16'h0001);
    chk("fan two forced", 16'(fan_two), 16'h0001);
    wr(8'h58, 8'hCE);
    wr(8'h5B, 8'hFD);
    wr(8'h56, 8'h40);
    wr(8'h57, 8'h40);
    repeat (16384) @(negedge sys_clk);
    n1 = 16'h0000;
    n2 = 16'h0000;
    repeat (16384) begin
      @(negedge sys_clk);
      n1 += 16'(fan_one);
      n2 += 16'(fan_two);
    end
    chk("fan one high", n1, 16'h2000);
    chk("fan two high", n2, 16'h2000);
    wr(8'h5C, 8'h20);
    repeat (1000) @(negedge sys_clk);
    rd(8'h59, 8'hFF);
    rd(8'h5A, 8'h20);
    // Freeze: a write is dropped and the fan pin stops toggling
    @(posedge sys_clk);
    clk_en <= 1'b0;
    wr(8'h5F, 8'hAA);
    @(negedge sys_clk);
    n1 = 16'(fan_one);
    n2 = 16'h0000;
    repeat (5000) begin
      @(negedge sys_clk);
      n2 += 16'(fan_one != n1[0]);
    end
    chk("frozen fan one", n2, 16'h0000);
    @(posedge sys_clk);
    clk_en <= 1'b1;
    rd(8'h5F, s);
    repeat (3) @(posedge sys_clk);
    tally_and_finish();
  end
  // Watchdog
  initial begin
    repeat (60000) @(posedge sys_clk);
    fails++;
    tally_and_finish();
  end
endmodule : ftl_regs_test
`default_nettype wire
